// ==== hw/ssr_top.sv ====
/*
 Status and readout register bank of a magnetic position sensor: status
 word, checksum, temperature and result words, threshold and interrupt
 registers behind a plain read/write port.
 Assumes the processing chain delivers results, flags and strobes
 synchronous to CLK_IN, and that strobes on the port are one cycle long.
*/
// The plain strobed port is this design's own decision.
// How it works
// - Status bit 15 reads 1 after a measurement finished and 0 while calculating or not ready.
// - The ready output pin always shows the same level as status bit 15.
// - Result words at 0110h-0114h and 0120h-0122h are stored by the same edge that raises bit 15.
// - Status bit 14 is set when the field magnitude is too low for a valid position.
// - The field is compared against the threshold in bits 7 to 0 of register 000Fh.
// - Status bit 13 is set when the ambiguous-angle correction overflows.
// - Status bit 11 is set when the temperature sensitivity correction overflows.
// - Status bit 9 is set when the converter histogram check fails.
// - Status bit 8 is the OR of bits 10, 9, 12 and 11.
// - Status bit 1 shows the magnet orientation in use, detected or configured.
// - Status bit 0 reads 0 during a memory write cycle and 1 once it is complete.
// - A read-only checksum word at 0108h covers the stored result words.
// - The temperature word at 0110h reads as (degrees Celsius - 25) times 200.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"

module ssr_top (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire ssr_pkg::ssr_bus_req_t BUS_IN,
	output ssr_pkg::ssr_word_t REG_RDATA_OUT,
	input wire logic MEAS_START_IN,
	input wire logic MEAS_DONE_IN,
	input wire ssr_pkg::ssr_result_t RESULT_IN,
	input wire ssr_pkg::ssr_flags_t FLAGS_IN,
	input wire logic [7:0] FIELD_MAG_IN,
	input wire logic ORIENT_DETECT_IN,
	input wire logic NVM_BUSY_IN,
	output logic READY_OUT,
	output logic IRQ_OUT
);
	import ssr_pkg::*;

	// ----------------------------------------------------------------
	// state and combinational nets
	// ----------------------------------------------------------------
	ssr_top_state_t s_reg;
	ssr_top_state_t s_next;

	ssr_word_t status_word;
	ssr_word_t read_mux;
	ssr_word_t crc_chain [0:`SSR_N_WORDS];
	logic [`SSR_IRQ_W-1:0] irq_set;
	logic [`SSR_IRQ_W-1:0] irq_clr;
	logic [`SSR_IRQ_W-1:0] irq_pending;
	logic wr_status_irq;
	logic new_weak;
	logic new_fault;
	logic orient_in_use;
	logic ready_flag;

	// ----------------------------------------------------------------
	// checksum over the incoming result words
	// ----------------------------------------------------------------
	assign crc_chain[0] = `SSR_CRC_INIT;

	genvar gi;
	generate
		for (gi = 0; gi < `SSR_N_WORDS; gi++) begin : g_crc
			ssr_crc_word u_crc (
				.crc_in(crc_chain[gi]),
				.data_in(RESULT_IN[gi]),
				.crc_out(crc_chain[gi+1])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// flags about to be captured with a finished measurement
	// ----------------------------------------------------------------
	assign new_weak = (FIELD_MAG_IN < s_reg.thresh[7:0]);

	assign new_fault = FLAGS_IN.converter_range_warning
		| FLAGS_IN.histogram_fault
		| FLAGS_IN.scale_overflow
		| FLAGS_IN.sensitivity_overflow;

	// configured orientation overrides the detected one
	assign orient_in_use = s_reg.orient_ctl[`SSR_OR_FORCE]
		? s_reg.orient_ctl[`SSR_OR_VALUE]
		: s_reg.orient_detected;

	assign ready_flag = (s_reg.phase == SSR_ST_DONE);

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	always_comb begin
		status_word = `SSR_ZERO16;
		status_word[`SSR_B_READY] = ready_flag;
		status_word[`SSR_B_WEAK] = s_reg.field_too_weak;
		status_word[`SSR_B_ANGLE] = s_reg.flags.angle_fix_overflow;
		status_word[`SSR_B_SCALE] = s_reg.flags.scale_overflow;
		status_word[`SSR_B_SENS] = s_reg.flags.sensitivity_overflow;
		status_word[`SSR_B_RANGE] = s_reg.flags.converter_range_warning;
		status_word[`SSR_B_HIST] = s_reg.flags.histogram_fault;
		status_word[`SSR_B_CALC] = s_reg.flags.converter_range_warning
			| s_reg.flags.histogram_fault
			| s_reg.flags.scale_overflow
			| s_reg.flags.sensitivity_overflow;
		status_word[`SSR_B_ORIENT] = orient_in_use;
		status_word[`SSR_B_NVM] = s_reg.nvm_write_done;
	end

	// ----------------------------------------------------------------
	// interrupt events and software clears
	// ----------------------------------------------------------------
	assign wr_status_irq = BUS_IN.wr && (BUS_IN.addr == `SSR_A_IRQ_STAT);

	always_comb begin
		irq_set = '0;
		irq_set[`SSR_IRQ_DONE] = MEAS_DONE_IN;
		irq_set[`SSR_IRQ_WEAK] = MEAS_DONE_IN && new_weak;
		irq_set[`SSR_IRQ_FAULT] = MEAS_DONE_IN && new_fault;
		irq_set[`SSR_IRQ_NVM] = !s_reg.nvm_write_done && !NVM_BUSY_IN;
	end

	assign irq_clr = wr_status_irq ? BUS_IN.wdata[`SSR_IRQ_W-1:0] : '0;

	generate
		for (gi = 0; gi < `SSR_IRQ_W; gi++) begin : g_irq
			ssr_irq_bit u_bit (
				.clk_in(CLK_IN),
				.rst_n_in(RST_N_IN),
				.set_in(irq_set[gi]),
				.clr_in(irq_clr[gi]),
				.pending_out(irq_pending[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	always_comb begin
		read_mux = `SSR_ZERO16;
		case (BUS_IN.addr)
			`SSR_A_THRESH: begin
				read_mux = s_reg.thresh;
			end
			`SSR_A_STATUS: begin
				read_mux = status_word;
			end
			`SSR_A_CRC: begin
				read_mux = s_reg.checksum;
			end
			`SSR_A_TEMP: begin
				read_mux = s_reg.result[0];
			end
			`SSR_A_BZ1: begin
				read_mux = s_reg.result[1];
			end
			`SSR_A_BZ0: begin
				read_mux = s_reg.result[2];
			end
			`SSR_A_BX1: begin
				read_mux = s_reg.result[3];
			end
			`SSR_A_BX0: begin
				read_mux = s_reg.result[4];
			end
			`SSR_A_POS0: begin
				read_mux = s_reg.result[5];
			end
			`SSR_A_POS1: begin
				read_mux = s_reg.result[6];
			end
			`SSR_A_POS2: begin
				read_mux = s_reg.result[7];
			end
			`SSR_A_IRQ_STAT: begin
				read_mux = {12'h000, irq_pending};
			end
			`SSR_A_IRQ_MASK: begin
				read_mux = {12'h000, s_reg.irq_mask};
			end
			`SSR_A_ORIENT: begin
				read_mux = {14'h0000, s_reg.orient_ctl};
			end
			default: begin
				read_mux = `SSR_ZERO16;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;

		// measurement phase
		case (s_reg.phase)
			SSR_ST_NOTREADY: begin
				if (MEAS_DONE_IN) begin
					s_next.phase = SSR_ST_DONE;
				end else if (MEAS_START_IN) begin
					s_next.phase = SSR_ST_CALC;
				end
			end
			SSR_ST_CALC: begin
				if (MEAS_DONE_IN) begin
					s_next.phase = SSR_ST_DONE;
				end
			end
			SSR_ST_DONE: begin
				if (MEAS_DONE_IN) begin
					s_next.phase = SSR_ST_DONE;
				end else if (MEAS_START_IN) begin
					s_next.phase = SSR_ST_CALC;
				end
			end
			default: begin
				s_next.phase = SSR_ST_NOTREADY;
			end
		endcase

		// results, flags and checksum land in the same edge that raises ready
		if (MEAS_DONE_IN) begin
			s_next.result = RESULT_IN;
			s_next.checksum = crc_chain[`SSR_N_WORDS];
			s_next.flags = FLAGS_IN;
			s_next.field_too_weak = new_weak;
			s_next.orient_detected = ORIENT_DETECT_IN;
		end

		s_next.nvm_write_done = !NVM_BUSY_IN;

		// only the configuration words take writes
		if (BUS_IN.wr) begin
			case (BUS_IN.addr)
				`SSR_A_THRESH: begin
					s_next.thresh = BUS_IN.wdata;
				end
				`SSR_A_IRQ_MASK: begin
					s_next.irq_mask = BUS_IN.wdata[`SSR_IRQ_W-1:0];
				end
				`SSR_A_ORIENT: begin
					s_next.orient_ctl = BUS_IN.wdata[1:0];
				end
				default: begin
					s_next.irq_mask = s_reg.irq_mask;
				end
			endcase
		end

		// read data stand only in the cycle after the strobe
		s_next.rdata = BUS_IN.rd ? read_mux : `SSR_ZERO16;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_reg <= '0;
			s_reg.phase <= SSR_ST_NOTREADY;
			s_reg.nvm_write_done <= 1'b1;
			s_reg.thresh <= `SSR_THRESH_RST;
			s_reg.irq_mask <= `SSR_MASK_RST;
			s_reg.orient_ctl <= `SSR_ORIENT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign READY_OUT = ready_flag;
	assign REG_RDATA_OUT = s_reg.rdata;
	assign IRQ_OUT = |(irq_pending & s_reg.irq_mask);

endmodule

`default_nettype wire

// ==== hw/ssr_consts.svh ====
/*
 Constants of the sensor status and readout register bank: register
 offsets, status field positions, reset values and checksum settings.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSR_A_THRESH 16'h000f
`define SSR_A_STATUS 16'h0107
`define SSR_A_CRC 16'h0108
`define SSR_A_TEMP 16'h0110
`define SSR_A_BZ1 16'h0111
`define SSR_A_BZ0 16'h0112
`define SSR_A_BX1 16'h0113
`define SSR_A_BX0 16'h0114
`define SSR_A_POS0 16'h0120
`define SSR_A_POS1 16'h0121
`define SSR_A_POS2 16'h0122
`define SSR_A_IRQ_STAT 16'h0130
`define SSR_A_IRQ_MASK 16'h0131
`define SSR_A_ORIENT 16'h0132

// ----------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------
`define SSR_B_READY 15
`define SSR_B_WEAK 14
`define SSR_B_ANGLE 13
`define SSR_B_SCALE 12
`define SSR_B_SENS 11
`define SSR_B_RANGE 10
`define SSR_B_HIST 9
`define SSR_B_CALC 8
`define SSR_B_ORIENT 1
`define SSR_B_NVM 0

// ----------------------------------------------------------------
// interrupt bits, orientation control bits, widths
// ----------------------------------------------------------------
`define SSR_IRQ_DONE 0
`define SSR_IRQ_WEAK 1
`define SSR_IRQ_FAULT 2
`define SSR_IRQ_NVM 3
`define SSR_IRQ_W 4
`define SSR_OR_FORCE 0
`define SSR_OR_VALUE 1
`define SSR_N_WORDS 8

// ----------------------------------------------------------------
// reset values and checksum settings
// ----------------------------------------------------------------
`define SSR_ZERO16 16'h0000
`define SSR_THRESH_RST 16'h0010
`define SSR_MASK_RST 4'h0
`define SSR_ORIENT_RST 2'h0
`define SSR_CRC_POLY 16'h1021
`define SSR_CRC_INIT 16'hffff

`endif

// ==== hw/ssr_pkg.sv ====
/*
 Types of the sensor status and readout register bank.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none

package ssr_pkg;

	typedef logic [15:0] ssr_word_t;

	// words in address order: temperature, four field words, three position words
	typedef ssr_word_t [7:0] ssr_result_t;

	typedef struct packed {
		logic angle_fix_overflow;
		logic scale_overflow;
		logic sensitivity_overflow;
		logic converter_range_warning;
		logic histogram_fault;
	} ssr_flags_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ssr_bus_req_t;

	typedef enum logic [2:0] {
		SSR_ST_NOTREADY = 3'b001,
		SSR_ST_CALC = 3'b010,
		SSR_ST_DONE = 3'b100
	} ssr_phase_t;

	typedef struct packed {
		logic pending;
	} ssr_irq_state_t;

	typedef struct packed {
		ssr_phase_t phase;
		ssr_result_t result;
		ssr_flags_t flags;
		logic field_too_weak;
		logic orient_detected;
		logic nvm_write_done;
		logic [15:0] thresh;
		logic [3:0] irq_mask;
		logic [1:0] orient_ctl;
		logic [15:0] checksum;
		logic [15:0] rdata;
	} ssr_top_state_t;

endpackage

`default_nettype wire

// ==== hw/ssr_irq_bit.sv ====
/*
 One sticky interrupt status bit: set by a hardware pulse, cleared by a
 software pulse. Assumes both pulses are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_irq_bit (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic set_in,
	input wire logic clr_in,
	output logic pending_out
);
	import ssr_pkg::*;

	ssr_irq_state_t s_reg;
	ssr_irq_state_t s_next;

	// set wins over a clear in the same cycle
	always_comb begin
		s_next = s_reg;
		if (set_in) begin
			s_next.pending = 1'b1;
		end else if (clr_in) begin
			s_next.pending = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pending_out = s_reg.pending;

endmodule

`default_nettype wire

// ==== hw/ssr_crc_word.sv ====
/*
 One step of the readout checksum: folds a 16-bit word into a running
 CRC, most significant bit first. Purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"

module ssr_crc_word (
	input wire ssr_pkg::ssr_word_t crc_in,
	input wire ssr_pkg::ssr_word_t data_in,
	output ssr_pkg::ssr_word_t crc_out
);
	import ssr_pkg::*;

	always_comb begin
		logic [15:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = c[15] ^ data_in[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ `SSR_CRC_POLY;
			end
		end
		crc_out = c;
	end

endmodule

`default_nettype wire

// ==== verification/ssr_top_chk.sv ====
/*
 Concurrent checks on the ports of the status and readout register bank.
 Assumes it is bound to ssr_top with every port connected by name.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_top_chk
	import ssr_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire ssr_pkg::ssr_bus_req_t BUS_IN,
	input wire ssr_pkg::ssr_word_t REG_RDATA_OUT,
	input wire logic MEAS_START_IN,
	input wire logic MEAS_DONE_IN,
	input wire ssr_pkg::ssr_result_t RESULT_IN,
	input wire logic NVM_BUSY_IN,
	input wire logic READY_OUT
);
	// ----------------------------------------------------------------
	// status read decode and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic st_rd;
	assign st_rd = BUS_IN.rd && (BUS_IN.addr == 16'h0107);

	property p_ready_mirror;
		st_rd |=> REG_RDATA_OUT[15] == $past(READY_OUT);
	endproperty
	a_ready_mirror: assert property (p_ready_mirror)
		else $error("ready pin and status bit differ");
	property p_start_drop;
		MEAS_START_IN && !MEAS_DONE_IN |=> !READY_OUT;
	endproperty
	a_start_drop: assert property (p_start_drop)
		else $error("ready stayed high after start");
	property p_done_rise;
		MEAS_DONE_IN |=> READY_OUT ##1 (READY_OUT || $past(MEAS_START_IN));
	endproperty
	a_done_rise: assert property (p_done_rise)
		else $error("ready not raised after done");
	property p_reserved;
		st_rd |=> REG_RDATA_OUT[7:2] == 6'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits not zero");
	property p_calc_or;
		st_rd |=> REG_RDATA_OUT[8] == (|REG_RDATA_OUT[12:9]);
	endproperty
	a_calc_or: assert property (p_calc_or)
		else $error("calculation fault bit wrong");
	property p_unmapped;
		BUS_IN.rd && BUS_IN.addr == 16'h0200 |=> REG_RDATA_OUT == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_nvm;
		st_rd |=> REG_RDATA_OUT[0] == !$past(NVM_BUSY_IN, 2);
	endproperty
	a_nvm: assert property (p_nvm)
		else $error("write done bit wrong");
	property p_temp;
		MEAS_DONE_IN ##1 (BUS_IN.rd && BUS_IN.addr == 16'h0110)
			|=> REG_RDATA_OUT == $past(RESULT_IN[0], 2);
	endproperty
	a_temp: assert property (p_temp)
		else $error("temperature word not stored");
endmodule

`default_nettype wire

// ==== verification/tb_ssr_top.sv ====
/*
 Self-checking testbench of the status and readout register bank.
 Assumes the package, constants header and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ssr_top;
	import ssr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic done = 1'b0;
	logic odet = 1'b0;
	logic busy = 1'b0;
	logic ready, irq, w;
	ssr_bus_req_t bus = '0;
	ssr_result_t res = '0;
	ssr_flags_t flg = '0;
	logic [7:0] mag = 8'h00;
	ssr_word_t rdata;
	logic [15:0] rnd = 16'h0033;
	logic [15:0] d;
	int miscompares = 0;
	int cmp_count = 0;

	always #4 clk = ~clk;

	ssr_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .BUS_IN(bus), .REG_RDATA_OUT(rdata),
		.MEAS_START_IN(start), .MEAS_DONE_IN(done), .RESULT_IN(res), .FLAGS_IN(flg),
		.FIELD_MAG_IN(mag), .ORIENT_DETECT_IN(odet), .NVM_BUSY_IN(busy),
		.READY_OUT(ready), .IRQ_OUT(irq));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] exp_st(input ssr_flags_t f, input logic wk, input logic o);
		return {1'b1, wk, f, |f[3:0], 6'h00, o, 1'b1};
	endfunction
	function automatic logic [15:0] crc_of(input ssr_result_t r);
		logic [15:0] c;
		c = 16'hffff;
		for (int k = 0; k < 128; k++) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ r[k / 16][15 - k % 16]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// a pending done pulse is dropped by the same edge that raises the read
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		done <= 1'b0;
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rc(16'h0107, 16'h0001);
		rc(16'h000f, 16'h0010);
		rc(16'h0200, 16'h0000);
		wr(16'h000f, 16'h1240);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			for (int j = 0; j < 8; j++) begin
				rnd = lfsr(rnd);
				res[j] <= rnd;
			end
			rnd = lfsr(rnd);
			flg <= rnd[4:0];
			odet <= rnd[5];
			mag <= (i == 0) ? 8'h3f : (i == 1) ? 8'h40 : rnd[15:8];
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			@(negedge clk);
			chk({15'h0000, ready}, 16'h0000);
			@(posedge clk);
			done <= 1'b1;
			rc(16'h0110, res[0]);
			chk({15'h0000, ready}, 16'h0001);
			w = mag < 8'h40;
			rc(16'h0107, exp_st(flg, w, odet));
			rc(16'h0108, crc_of(res));
			for (int j = 1; j < 8; j++) begin
				rc((j < 5) ? 16'(16'h0110 + j) : 16'(16'h011b + j), res[j]);
			end
			if (i == 0) begin
				wr(16'h0107, 16'h0000);
				wr(16'h0108, ~crc_of(res));
				wr(16'h0110, ~res[0]);
				rc(16'h0107, exp_st(flg, w, odet));
				rc(16'h0108, crc_of(res));
				rc(16'h0110, res[0]);
			end
		end
		wr(16'h0132, 16'h0003);
		rc(16'h0107, exp_st(flg, w, 1'b1));
		wr(16'h0132, 16'h0001);
		rc(16'h0107, exp_st(flg, w, 1'b0));
		wr(16'h0131, 16'h0001);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0001);
		wr(16'h0130, 16'h000f);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0000);
		@(posedge clk);
		busy <= 1'b1;
		rc(16'h0107, exp_st(flg, w, 1'b0) & 16'hfffe);
		@(posedge clk);
		busy <= 1'b0;
		rc(16'h0130, 16'h0008);
		rc(16'h0107, exp_st(flg, w, 1'b0));
		wr(16'h0131, 16'h0008);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0001);
		wr(16'h0131, 16'h0000);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0000);
		stop_test();
	end
endmodule

bind ssr_top ssr_top_chk u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .BUS_IN(BUS_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .MEAS_START_IN(MEAS_START_IN), .MEAS_DONE_IN(MEAS_DONE_IN),
	.RESULT_IN(RESULT_IN), .NVM_BUSY_IN(NVM_BUSY_IN), .READY_OUT(READY_OUT));

`default_nettype wire
